// file: design/tpuc_timer.sv
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Notes on behaviour
// [RQ1] internal clock with gate set counts only while gate active; external ignores gate
// [RQ2] prescale field 11,10,01,00 divides input clock by 256, 64, 8, 1
// [RQ3] unimplemented control bits read zero and ignore writes
// [RQ4] idle halt bit set stops counting in idle; clear keeps running
// [RQ5] when pair joined, own run, gate, prescale, source bits have no effect
// [RQ6] software clears idle halt bit to keep joined timer running in idle; here a joined half stays put whatever that bit holds
// [RQ7] run bit starts/stops timer; source bit picks internal clock or pin rising edges
module tpuc_timer import tpuc_pkg::*; (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // timer pins and system state
  input  wire logic        external_count_pin,
  input  wire logic        gate_in,
  input  wire logic        idle_mode,
  // timer status
  output logic             count_tick,
  output logic [15:0]      count_value
);
  tpuc_state_t q, d;

  // byte lanes 1:0 only; the upper half of the bus has no storage
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] ws);
    merge16 = {ws[1] ? wd[15:8] : old[15:8], ws[0] ? wd[7:0] : old[7:0]};
  endfunction

  // word select shared by the write and read decoders
  function automatic logic [3:0] word_addr(input logic [3:0] addr);
    word_addr = {addr[3:2], 2'b00};
  endfunction

  // terminal prescaler value for each select code
  function automatic logic [7:0] div_terminal(input logic [1:0] sel);
    unique case (sel) // RQ2
      2'b00: div_terminal = TPUC_DIV_1;
      2'b01: div_terminal = TPUC_DIV_8;
      2'b10: div_terminal = TPUC_DIV_64;
      2'b11: div_terminal = TPUC_DIV_256;
    endcase
  endfunction

  logic        pair_join_flag;
  logic        run_enable;
  logic        run_active;
  logic        gate_accumulate_enable;
  logic        count_source_select;
  logic [1:0]  input_prescale_select;
  logic        pin_rise;
  logic        input_edge;
  logic        idle_halt;
  logic        counting;
  logic        pre_done;
  logic [7:0]  div_last;
  logic        wr_go;
  logic        rd_go;

  // every bus output is a flop of its own, ready included
  assign s_axi_awready = q.aw_rdy;
  assign s_axi_wready  = q.w_rdy;
  assign s_axi_arready = q.ar_rdy;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign count_tick    = q.tick;
  assign count_value   = q.count;

  always_comb begin
    pair_join_flag         = q.partner[TPUC_JOIN_BIT];
    run_enable             = q.ctrl[TPUC_RUN_BIT];
    // joined pair: the partner's control governs, this half stays put
    run_active             = run_enable & ~pair_join_flag; // RQ5 RQ7
    gate_accumulate_enable = q.ctrl[TPUC_GATE_BIT];
    count_source_select    = q.ctrl[TPUC_SRC_BIT];
    input_prescale_select  = q.ctrl[TPUC_PS_LSB +: 2];
    div_last               = div_terminal(input_prescale_select); // RQ2
    // pin taken synchronous; a rising edge is one input clock
    pin_rise   = external_count_pin & ~q.ext_prev;
    input_edge = count_source_select ? pin_rise // RQ7
                                     : (~gate_accumulate_enable | gate_in); // RQ1
    idle_halt  = idle_mode & q.ctrl[TPUC_IDLE_BIT]; // RQ4
    counting   = run_active & ~idle_halt & input_edge;
    // >= so a smaller select taken mid-run wraps at once, not after 256
    pre_done   = counting & (q.pre >= div_last); // RQ2
    wr_go      = q.awv & q.wv & ~q.bvalid;
    rd_go      = s_axi_arvalid & q.ar_rdy;

    d          = q;
    d.ext_prev = external_count_pin;
    d.tick     = 1'b0;
    if (counting) begin
      d.pre = pre_done ? 8'h00 : q.pre + 8'h01; // RQ2
    end
    if (pre_done) begin
      d.count = q.count + 16'h0001;
      d.tick  = 1'b1;
    end
    // stopping clears the prescaler so a restart divides from zero
    if (!run_active) begin
      d.pre = 8'h00;
    end

    if (s_axi_awvalid && q.aw_rdy) begin
      d.awv = 1'b1;
      d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.w_rdy) begin
      d.wv = 1'b1;
      d.wd = s_axi_wdata;
      d.ws = s_axi_wstrb;
    end
    if (wr_go) begin
      d.awv    = 1'b0;
      d.wv     = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = TPUC_RESP_OKAY;
      unique case (word_addr(q.awa))
        TPUC_CTRL_OFFSET:    d.ctrl = merge16(q.ctrl, q.wd, q.ws) & TPUC_CTRL_MASK; // RQ3
        TPUC_PARTNER_OFFSET: d.partner = merge16(q.partner, q.wd, q.ws);
        TPUC_COUNT_OFFSET:   d.count = merge16(q.count, q.wd, q.ws);
        default:             d.bresp = TPUC_RESP_SLVERR;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rresp  = TPUC_RESP_OKAY;
      unique case (word_addr(s_axi_araddr))
        TPUC_CTRL_OFFSET:    d.rdata = {16'h0000, q.ctrl & TPUC_CTRL_MASK}; // RQ3
        TPUC_PARTNER_OFFSET: d.rdata = {16'h0000, q.partner};
        TPUC_COUNT_OFFSET:   d.rdata = {16'h0000, q.count};
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = TPUC_RESP_SLVERR;
        end
      endcase
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    // ready flops track the slots one cycle ahead of the bus
    d.aw_rdy = ~d.awv;
    d.w_rdy  = ~d.wv;
    d.ar_rdy = ~d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q        <= '0;
      q.ctrl   <= TPUC_CTRL_RESET;
      q.aw_rdy <= TPUC_READY_RESET;
      q.w_rdy  <= TPUC_READY_RESET;
      q.ar_rdy <= TPUC_READY_RESET;
    end else begin
      q <= d;
    end
  end

  // checks look at the registered tick, count or prescaler, one edge after the cause; a_unimpl_zero checks ctrl on every edge
  a_join_blocks: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
    pair_join_flag |=> $stable(q.count) || $past(wr_go))
    else $error("count moved while pair joined");
  a_join_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
    pair_join_flag |=> !q.tick)
    else $error("tick while pair joined");
  a_idle_halt: assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
    idle_halt |=> !q.tick)
    else $error("tick in idle with halt set");
  a_gate_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
    (!count_source_select && gate_accumulate_enable && !gate_in) |=> !q.tick)
    else $error("counted with gate low");
  a_ext_edge: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
    (count_source_select && !pin_rise) |=> !q.tick)
    else $error("external count without rising edge");
  a_ext_counts: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
    (count_source_select && pin_rise && run_active && !idle_halt
     && input_prescale_select == 2'b00) |=> q.tick)
    else $error("external rising edge not counted");
  a_run_off: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
    !run_enable |=> !q.tick)
    else $error("tick while stopped");
  a_pre_cleared: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
    !run_active |=> q.pre == 8'h00)
    else $error("prescaler kept while stopped");
  a_div_one: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
    (counting && input_prescale_select == 2'b00) |=> q.tick)
    else $error("divide by one missed tick");

  // divide by eight: a terminal count leaves seven input clocks without one
  sequence s_div8_done;
    pre_done && input_prescale_select == 2'b01;
  endsequence
  sequence s_div8_held;
    (input_prescale_select == 2'b01) [*7];
  endsequence
  a_div_eight: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
    s_div8_done ##1 s_div8_held |=> !q.tick)
    else $error("divide by eight wrong");

  a_count_step: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
    (pre_done && !wr_go) |=> q.count == $past(q.count) + 16'h0001)
    else $error("count did not step by one");
  a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
    (q.ctrl & ~TPUC_CTRL_MASK) == 16'h0000)
    else $error("unimplemented bit set");
endmodule

// file: design/tpuc_pkg.sv
package tpuc_pkg;
  // control register, byte address on the register bus
  localparam logic [3:0]  TPUC_CTRL_OFFSET   = 4'h0;
  // partner control mirror (pair join flag lives in bit 3), read-write here
  localparam logic [3:0]  TPUC_PARTNER_OFFSET = 4'h4;
  // count status, read-write here
  localparam logic [3:0]  TPUC_COUNT_OFFSET  = 4'h8;
  localparam logic [15:0] TPUC_CTRL_RESET    = 16'h0000;
  localparam logic [15:0] TPUC_CTRL_MASK     = 16'ha072;
  localparam logic        TPUC_READY_RESET   = 1'b1;
  localparam int          TPUC_RUN_BIT       = 15;
  localparam int          TPUC_IDLE_BIT      = 13;
  localparam int          TPUC_GATE_BIT      = 6;
  localparam int          TPUC_PS_LSB        = 4;
  localparam int          TPUC_SRC_BIT       = 1;
  localparam int          TPUC_JOIN_BIT      = 3;
  localparam logic [7:0]  TPUC_DIV_1         = 8'h00;
  localparam logic [7:0]  TPUC_DIV_8         = 8'h07;
  localparam logic [7:0]  TPUC_DIV_64        = 8'h3f;
  localparam logic [7:0]  TPUC_DIV_256       = 8'hff;
  localparam logic [1:0]  TPUC_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  TPUC_RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] partner;
    logic [7:0]  pre;
    logic [15:0] count;
    logic        tick;
    logic        ext_prev;
    logic        awv;
    logic [3:0]  awa;
    logic        wv;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        aw_rdy;
    logic        w_rdy;
    logic        ar_rdy;
  } tpuc_state_t;
endpackage

// file: tb/timer_pair_upper_control_test.sv
`timescale 1ns/100ps
module timer_pair_upper_control_test import tpuc_pkg::*;;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, pin, gate, idle, tick, toggle;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs, bs;
  logic [15:0] count;
  int          bad_count, num_checks, cyc;

  tpuc_timer u_tpuc_timer (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .external_count_pin(pin),
    .gate_in(gate), .idle_mode(idle), .count_tick(tick), .count_value(count));

  always #5 aclk = ~aclk;
  // one rising pin edge every two cycles
  always @(posedge aclk) if (toggle) pin <= ~pin;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
    end while (bvalid !== 1'b1);
    bs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      arvalid <= arvalid & ~arready;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // a 256-cycle window holds a whole number of periods for every divider
  task automatic meas(input logic [15:0] c, input logic [31:0] e);
    logic [31:0] n;
    logic [15:0] c0;
    wr(TPUC_CTRL_OFFSET, c);
    repeat (4) @(posedge aclk);
    n = 0;
    c0 = count;
    repeat (256) begin
      @(posedge aclk);
      if (tick === 1'b1) n++;
    end
    chk("ticks", e, n);
    chk("count steps", e, {16'h0000, count - c0});
  endtask

  task automatic t_regs();
    rd_reg(TPUC_CTRL_OFFSET);
    chk("ctrl reset", 32'h0, rd);
    wr(TPUC_CTRL_OFFSET, 16'hffff);
    chk("ctrl bresp", {30'h0, TPUC_RESP_OKAY}, {30'h0, bs});
    rd_reg(TPUC_CTRL_OFFSET);
    chk("ctrl mask", 32'ha072, rd);
    wr(TPUC_CTRL_OFFSET, 16'h0000);
    wr(TPUC_COUNT_OFFSET, 16'h1234);
    rd_reg(TPUC_COUNT_OFFSET);
    chk("count read", 32'h1234, rd);
    chk("count port", 32'h1234, {16'h0000, count});
    wr(4'hc, 16'h5a5a);
    chk("unmapped bresp", {30'h0, TPUC_RESP_SLVERR}, {30'h0, bs});
    rd_reg(4'hc);
    chk("unmapped resp", {30'h0, TPUC_RESP_SLVERR}, {30'h0, rs});
    chk("unmapped data", 32'h0, rd);
  endtask

  task automatic t_prescale();
    meas(16'h8000, 256);
    meas(16'h8010, 32);
    meas(16'h8020, 4);
    meas(16'h8030, 1);
    meas(16'h0000, 0);
  endtask

  task automatic t_gate();
    meas(16'h8040, 0);
    gate <= 1'b1;
    meas(16'h8040, 256);
    gate <= 1'b0;
    toggle <= 1'b1;
    meas(16'h8042, 128);
    toggle <= 1'b0;
  endtask

  task automatic t_idle();
    idle <= 1'b1;
    meas(16'ha000, 0);
    meas(16'h8000, 256);
    idle <= 1'b0;
  endtask

  task automatic t_join();
    wr(TPUC_PARTNER_OFFSET, 16'h0008);
    rd_reg(TPUC_PARTNER_OFFSET);
    chk("partner join", 32'h8, rd);
    idle <= 1'b1;
    meas(16'h8000, 0);
    idle <= 1'b0;
    meas(16'h8072, 0);
    wr(TPUC_PARTNER_OFFSET, 16'h0000);
    meas(16'h8000, 256);
  endtask

  // reset in mid-run: counter and control drop, ready comes back high
  task automatic t_reset();
    wr(TPUC_CTRL_OFFSET, 16'h8000);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("reset count", 32'h0, {16'h0000, count});
    chk("reset ready", 32'h7, {29'h0, awready, wready, arready});
    rd_reg(TPUC_CTRL_OFFSET);
    chk("reset ctrl", 32'h0, rd);
  endtask

  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {pin, gate, idle, toggle, awaddr, araddr, wstrb, wdata} = '0;
    {bad_count, num_checks, cyc} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_prescale();
    t_gate();
    t_idle();
    t_join();
    t_reset();
    print_verdict();
  end
endmodule
